// [src/ltc_pkg.sv]
// constants, register map and carrier types of the link and transaction register bank
// What this block does
// (R1) full-packet select set: upstream buffers whole packet; clear: cut-through
// (R2) cut-through start is mid-packet minus early-forward code cycles, upstream only
// (R3) arbiter hold set: stay on granted port while its request pends
// (R4) arbiter hold clear: move to a requesting port with enough credit
// (R5) non-posted whole-buffer set: non-posted packets fully stored before forwarding
// (R6) posted-no-pass set: posted never overtakes an earlier non-posted packet
// (R7) cross-egress ordering set: strict order among packets for different egress ports
// (R8) completion tag ordering set: completions with different tags kept in order
// (R9) page-crossing bit set: check requests for 4KB crossing; clear: no check
// (R10) receive power ack count writable, values 0 to 6, resets to 3
// (R11) transmit power ack count, values 0 to 6, resets to 0
// (R12) read-only wide consecutive-packet tally in top nibble, cleared through bit 2
// (R13) writing one to link-layer reset bit resets link layer; writing one clears
// (R14) nullify enable, reset set, allows generating nullified packets
// (R15) flags: nullified seen, length mismatch, sequence fault, retry store full
// (R16) flags: ECC fix/fatal, retransmit timeout, short/long check fail, nullified check
// (R17) last negative-ack sequence per direction recorded, receive 11:0, transmit 27:16, flags
// (R18) whole-chip cross-domain bit: 1 cross-domain, 0 transparent
// (R19) shared-memory disable set only via port 0, switch-wide, 1 disables
// (R20) legacy video decode bit, 1 enables, resets enabled
// (R21) bifurcation enable bit turns bifurcation on, off at reset
// (R22) three writable four-bit skew windows, one per rate, reset to C
// (R23) reserved fields read their defaults and ignore writes
package ltc_pkg;
    localparam int unsigned NUM_RW = 8;
    localparam logic [11:0] OFF_TALLY_CTRL = 12'h450;
    localparam logic [11:0] OFF_LINK_ERR = 12'h454;
    localparam logic [11:0] OFF_NAK_REC = 12'h458;
    localparam logic [11:0] OFF_MISC_CTRL = 12'h45C;
    localparam logic [11:0] OFF_LINK_TX_DBG = 12'h460;
    localparam logic [11:0] OFF_LINK_RX_DBG = 12'h464;
    localparam logic [11:0] OFF_MAC_TX_DBG = 12'h468;
    localparam logic [11:0] OFF_MAC_RX_DBG = 12'h46C;
    localparam logic [11:0] OFF_ANALYZER = 12'h470;
    localparam logic [11:0] OFF_TL_CAP = 12'h4C0;
    localparam logic [11:0] OFF_FWD_ORDER = 12'h4C4;
    localparam logic [11:0] OFF_TL_MODE = 12'h4C8;
    localparam logic [11:0] OFF_VP_RING = 12'h4CC;
    localparam logic [11:0] OFF_TL_DBG_SEL = 12'h4D0;
    localparam logic [11:0] OFF_DEV_CFG0 = 12'h504;
    // index order of the writable words
    localparam logic [2:0] IDX_TALLY_CTRL = 3'h0;
    localparam logic [2:0] IDX_LINK_ERR = 3'h1;
    localparam logic [2:0] IDX_MISC_CTRL = 3'h2;
    localparam logic [2:0] IDX_FWD_ORDER = 3'h5;
    localparam logic [11:0] RW_OFF [NUM_RW] = '{12'h450, 12'h454, 12'h45C, 12'h470,
                                              12'h4C0, 12'h4C4, 12'h4C8, 12'h4D0};
    localparam logic [31:0] RW_MASK [NUM_RW] = '{32'h0000_07FF, 32'h0007_7000, 32'h7FFF_FFFD,
                                               32'hFFFF_FFFF, 32'h0000_0701, 32'h0007_EDFF,
                                               32'h0000_00F0, 32'hFF00_0000};
    localparam logic [31:0] RW_RST [NUM_RW] = '{32'h0000_07F9, 32'h0000_3000, 32'h0CCC_2C81,
                                              32'h0000_00CB, 32'h0000_0001, 32'h0000_8008,
                                              32'h0000_0010, 32'h0000_0000};
    // fixed read values of reserved and read-only parts
    localparam logic [31:0] TALLY_RSVD = 32'h0002_8000;
    localparam logic [31:0] LINK_ERR_RSVD_NARROW = 32'h1F18_8000;
    localparam logic [31:0] LINK_ERR_RSVD_WIDE = 32'h0F18_8000;
    localparam logic [31:0] TL_MODE_FIXED = 32'h0000_0004;
    localparam logic [31:0] LINK_TX_DBG_VAL = 32'h0000_0070;
    localparam logic [31:0] MAC_TX_DBG_VAL = 32'h0098_0029;
    localparam logic [31:0] VP_RING_VAL = 32'h0000_000A;
    // field positions
    localparam int unsigned TALLY_RUN_BIT = 2;
    localparam int unsigned TALLY_LSB = 28;
    localparam int unsigned RCV_ACK_LSB = 12;
    localparam int unsigned XMIT_ACK_LSB = 16;
    localparam logic [2:0] PM_ACK_MAX = 3'h6;
    localparam int unsigned NULLIFY_BIT = 0;
    localparam int unsigned DLL_RST_BIT = 1;
    localparam int unsigned SKEW1_LSB = 16;
    localparam int unsigned SKEW2_LSB = 20;
    localparam int unsigned SKEW3_LSB = 24;
    localparam int unsigned BIFURC_BIT = 29;
    localparam int unsigned VGA_BIT = 0;
    localparam int unsigned MEMSHARE_BIT = 5;
    localparam int unsigned STORE_BIT = 0;
    localparam int unsigned EARLY_LSB = 1;
    localparam int unsigned HOLD_BIT = 4;
    localparam int unsigned XEGRESS_BIT = 5;
    localparam int unsigned CPL_BIT = 6;
    localparam int unsigned NPW_BIT = 7;
    localparam int unsigned PAGE_BIT = 11;
    localparam int unsigned PNP_BIT = 13;
    localparam int unsigned RX_NAK_FLAG_BIT = 15;
    localparam int unsigned TX_NAK_LSB = 16;
    localparam int unsigned TX_NAK_FLAG_BIT = 31;
    localparam int unsigned CD_BIT = 6;
    localparam logic [13:0] PAGE_BYTES = 14'h1000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } ltc_cfg_req_t;

    typedef struct packed {
        logic nullified_seen;
        logic length_mismatch_seen;
        logic sequence_fault_seen;
        logic retry_store_full;
        logic ecc_fix_seen;
        logic ecc_fatal_seen;
        logic retransmit_timeout_seen;
        logic short_check_fail;
        logic long_check_fail;
        logic nullified_check_seen;
        logic nak_rx;
        logic nak_tx;
        logic [11:0] nak_rx_seq;
        logic [11:0] nak_tx_seq;
    } ltc_link_evt_t;

    typedef struct packed {
        logic store_whole;
        logic [1:0] early_code;
        logic arb_hold;
        logic cross_egress_order;
        logic cpl_tag_order;
        logic nonposted_whole_buffer;
        logic posted_no_pass_nonposted;
        logic page_crossing_check;
        logic nullify_en;
        logic dll_reset;
        logic bifurcate_en;
        logic vga_decode;
        logic mem_share_off;
        logic whole_chip_cross_domain;
        logic [2:0] up_port_sel;
        logic [2:0] rcv_power_ack_count;
        logic [2:0] xmit_power_ack_count;
        logic [3:0] rate1_skew_window;
        logic [3:0] rate2_skew_window;
        logic [3:0] rate3_skew_window;
    } ltc_policy_t;
endpackage

// [src/ltc_rr_arbiter.sv]
// round-robin egress arbiter with optional hold on the granted port
module ltc_rr_arbiter #(
    parameter int unsigned PORTS = 4
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic hold_i,
    input wire logic advance_i,
    input wire logic [PORTS-1:0] req_i,
    input wire logic [PORTS-1:0] credit_ok_i,
    output logic [PORTS-1:0] grant_o
);
    localparam int unsigned IW = (PORTS > 1) ? $clog2(PORTS) : 1;
    logic [IW-1:0] cur;
    logic gnt_valid;
    logic keep;
    logic found;
    logic [IW-1:0] pick;
    logic [PORTS-1:0] eligible;

    assign eligible = req_i & credit_ok_i;
    // hold ignores credit so a starved big packet is not overtaken
    assign keep = gnt_valid && req_i[cur] && !advance_i && (hold_i || credit_ok_i[cur]); // R3

    always_comb begin
        logic [IW-1:0] k;
        k = cur;
        found = 1'b0;
        pick = cur;
        for (int unsigned i = 1; i <= PORTS; i++) begin
            k = (k == IW'(PORTS - 1)) ? '0 : IW'(k + 1'b1);
            if (!found && eligible[k]) begin
                found = 1'b1;
                pick = k;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur <= '0;
            gnt_valid <= 1'b0;
        end else if (!keep) begin
            cur <= pick; // R4
            gnt_valid <= found;
        end
    end

    always_comb begin
        grant_o = '0;
        grant_o[cur] = gnt_valid;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    hold_stays_a: assert property (hold_i && gnt_valid && req_i[cur] && !advance_i |=> // R3
        $stable(cur) && gnt_valid) else $error("held grant moved");
    credit_move_a: assert property (!keep && found |=> gnt_valid && // R4
        ($past(eligible) & grant_o) != '0) else $error("grant to ineligible port");
endmodule

// [src/ltc_csr_bank.sv]
// per-port link and transaction control and status register bank with policy outputs
module ltc_csr_bank
    import ltc_pkg::*;
#(
    parameter int unsigned PORTS = 4,
    parameter logic IS_PORT0 = 1'b1,
    parameter logic WIDE_LINK = 1'b0,
    parameter int unsigned LEN_W = 10
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire ltc_pkg::ltc_cfg_req_t cfg_req_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    input wire ltc_pkg::ltc_link_evt_t link_evt_i,
    input wire logic b2b_pulse_i,
    input wire logic strap_cross_domain_i,
    input wire logic [2:0] strap_up_port_i,
    input wire logic strap_mem_share_off_i,
    output ltc_pkg::ltc_policy_t policy_o,
    input wire logic [LEN_W-1:0] pkt_len_i,
    input wire logic [LEN_W-1:0] pkt_beat_i,
    input wire logic pkt_nonposted_i,
    output logic fwd_start_o,
    input wire logic np_pending_i,
    output logic posted_hold_o,
    input wire logic [11:0] req_addr_i,
    input wire logic [12:0] req_bytes_i,
    output logic page_cross_o,
    input wire logic arb_advance_i,
    input wire logic [PORTS-1:0] arb_req_i,
    input wire logic [PORTS-1:0] arb_credit_ok_i,
    output logic [PORTS-1:0] arb_grant_o
);
    import ltc_pkg::*;

    function automatic logic [3:0] find_rw(input logic [11:0] addr);
        find_rw = 4'h0;
        for (int unsigned i = 0; i < NUM_RW; i++) begin
            if (addr == RW_OFF[i]) begin
                find_rw = {1'b1, 3'(i)};
            end
        end
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be, input logic [31:0] msk);
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        byte_merge = (old & ~lanes) | (nw & lanes);
    endfunction

    logic [31:0] rw_q [NUM_RW];
    logic [31:0] ro_part [NUM_RW];
    logic [3:0] tally;
    logic [9:0] flags;
    logic [11:0] rx_nak_seq;
    logic [11:0] tx_nak_seq;
    logic rx_nak_flag;
    logic tx_nak_flag;
    logic dll_rst;
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic [4:0] strap_s3;
    logic [4:0] strap_val;

    // bus decode
    logic [3:0] hit_w;
    logic is_wr;
    logic [31:0] wdata_adj;
    logic [31:0] next_rdata;
    logic dll_wr_one;
    assign hit_w = find_rw(cfg_req_i.addr);
    assign is_wr = cfg_req_i.valid && cfg_req_i.write;
    assign dll_wr_one = is_wr && cfg_req_i.addr == OFF_MISC_CTRL && cfg_req_i.be[0] &&
                        cfg_req_i.wdata[DLL_RST_BIT];

    // out-of-range power ack counts are dropped, the field keeps its value
    logic [2:0] rcv_wr;
    logic [2:0] xmit_wr;
    logic [31:0] link_err_q;
    assign link_err_q = rw_q[IDX_LINK_ERR];
    assign rcv_wr = cfg_req_i.wdata[RCV_ACK_LSB +: 3];
    assign xmit_wr = cfg_req_i.wdata[XMIT_ACK_LSB +: 3];
    always_comb begin
        wdata_adj = cfg_req_i.wdata;
        if (hit_w[2:0] == IDX_LINK_ERR) begin
            if (rcv_wr > PM_ACK_MAX) begin
                wdata_adj[RCV_ACK_LSB +: 3] = link_err_q[RCV_ACK_LSB +: 3]; // R10
            end
            if (xmit_wr > PM_ACK_MAX) begin
                wdata_adj[XMIT_ACK_LSB +: 3] = link_err_q[XMIT_ACK_LSB +: 3]; // R11
            end
        end
    end

    // writable words; masks keep reserved and read-only bits out of reach
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int unsigned i = 0; i < NUM_RW; i++) begin
                rw_q[i] <= RW_RST[i]; // R10 R11 R14 R20 R21 R22
            end
        end else if (is_wr && hit_w[3]) begin
            rw_q[hit_w[2:0]] <= byte_merge(rw_q[hit_w[2:0]], wdata_adj, cfg_req_i.be,
                                           RW_MASK[hit_w[2:0]]); // R23
        end
    end

    // link-layer reset bit: a written one flips it, so one write enters and one leaves
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dll_rst <= 1'b0;
        end else if (dll_wr_one) begin
            dll_rst <= !dll_rst; // R13
        end
    end

    // error flags: sticky, wiped while the link layer is held in reset; a new event wins
    logic [9:0] evt_flags;
    assign evt_flags = {link_evt_i.nullified_check_seen, link_evt_i.long_check_fail,
                        link_evt_i.short_check_fail, link_evt_i.retransmit_timeout_seen,
                        link_evt_i.ecc_fatal_seen, link_evt_i.ecc_fix_seen,
                        link_evt_i.retry_store_full, link_evt_i.sequence_fault_seen,
                        link_evt_i.length_mismatch_seen, link_evt_i.nullified_seen};
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags <= '0;
        end else begin
            flags <= (dll_rst ? 10'h000 : flags) | evt_flags; // R15 R16
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_nak_seq <= '0;
            tx_nak_seq <= '0;
            rx_nak_flag <= 1'b0;
            tx_nak_flag <= 1'b0;
        end else begin
            rx_nak_flag <= link_evt_i.nak_rx || (rx_nak_flag && !dll_rst); // R17
            tx_nak_flag <= link_evt_i.nak_tx || (tx_nak_flag && !dll_rst); // R17
            if (link_evt_i.nak_rx) begin
                rx_nak_seq <= link_evt_i.nak_rx_seq; // R17
            end
            if (link_evt_i.nak_tx) begin
                tx_nak_seq <= link_evt_i.nak_tx_seq; // R17
            end
        end
    end

    // consecutive-packet tally runs while its enable is set and is held clear otherwise
    logic tally_run;
    assign tally_run = rw_q[IDX_TALLY_CTRL][TALLY_RUN_BIT];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tally <= '0;
        end else if (!tally_run) begin
            tally <= '0; // R12
        end else if (b2b_pulse_i && tally != 4'hF) begin
            tally <= tally + 4'h1;
        end
    end

    // straps come from pins: three flops, a change counts once the last two agree
    logic [4:0] strap_pins;
    assign strap_pins = {strap_cross_domain_i, strap_up_port_i, strap_mem_share_off_i};
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_s1 <= '0;
            strap_s2 <= '0;
            strap_s3 <= '0;
            strap_val <= '0;
        end else begin
            strap_s1 <= strap_pins;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            for (int unsigned i = 0; i < 5; i++) begin
                if (strap_s2[i] == strap_s3[i]) begin
                    strap_val[i] <= strap_s3[i];
                end
            end
        end
    end

    // only port 0 owns the switch-wide sharing switch; other ports read it as zero
    logic mem_share_off;
    assign mem_share_off = IS_PORT0 && strap_val[0]; // R19

    // read-only parts laid over the writable words
    always_comb begin
        for (int unsigned i = 0; i < NUM_RW; i++) begin
            ro_part[i] = '0;
        end
        ro_part[IDX_TALLY_CTRL] = TALLY_RSVD | {tally, 28'h0000000}; // R12
        ro_part[IDX_LINK_ERR] = (WIDE_LINK ? LINK_ERR_RSVD_WIDE : LINK_ERR_RSVD_NARROW) |
                                {22'h000000, flags}; // R15 R16 R23
        ro_part[IDX_MISC_CTRL] = {30'h00000000, dll_rst, 1'b0};
        ro_part[4] = {26'h0000000, mem_share_off, 5'h00};
        ro_part[6] = TL_MODE_FIXED;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_w[3]) begin
            next_rdata = (rw_q[hit_w[2:0]] & RW_MASK[hit_w[2:0]]) | ro_part[hit_w[2:0]];
        end else begin
            case (cfg_req_i.addr)
                OFF_NAK_REC: begin
                    next_rdata = {tx_nak_flag, 3'h0, tx_nak_seq, rx_nak_flag, 3'h0, rx_nak_seq};
                end
                OFF_LINK_TX_DBG: next_rdata = LINK_TX_DBG_VAL;
                OFF_MAC_TX_DBG: next_rdata = MAC_TX_DBG_VAL;
                OFF_VP_RING: next_rdata = IS_PORT0 ? VP_RING_VAL : 32'h0000_0000;
                OFF_DEV_CFG0: begin
                    next_rdata = IS_PORT0 ? {25'h0000000, strap_val[4], 3'h0, strap_val[3:1]}
                                          : 32'h0000_0000; // R18
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= '0;
        end else begin
            cfg_ack_o <= cfg_req_i.valid;
            if (cfg_req_i.valid && !cfg_req_i.write) begin
                cfg_rdata_o <= next_rdata;
            end
        end
    end

    // policy fan-out
    logic [31:0] fwd_q;
    logic [31:0] misc_q;
    assign fwd_q = rw_q[IDX_FWD_ORDER];
    assign misc_q = rw_q[IDX_MISC_CTRL];
    always_comb begin
        policy_o.store_whole = fwd_q[STORE_BIT];
        policy_o.early_code = fwd_q[EARLY_LSB +: 2];
        policy_o.arb_hold = fwd_q[HOLD_BIT];
        policy_o.cross_egress_order = fwd_q[XEGRESS_BIT]; // R7
        policy_o.cpl_tag_order = fwd_q[CPL_BIT]; // R8
        policy_o.nonposted_whole_buffer = fwd_q[NPW_BIT];
        policy_o.posted_no_pass_nonposted = fwd_q[PNP_BIT];
        policy_o.page_crossing_check = fwd_q[PAGE_BIT];
        policy_o.nullify_en = misc_q[NULLIFY_BIT]; // R14
        policy_o.dll_reset = dll_rst; // R13
        policy_o.bifurcate_en = misc_q[BIFURC_BIT]; // R21
        policy_o.vga_decode = rw_q[4][VGA_BIT]; // R20
        policy_o.mem_share_off = mem_share_off; // R19
        policy_o.whole_chip_cross_domain = strap_val[4]; // R18
        policy_o.up_port_sel = strap_val[3:1];
        policy_o.rcv_power_ack_count = link_err_q[RCV_ACK_LSB +: 3];
        policy_o.xmit_power_ack_count = link_err_q[XMIT_ACK_LSB +: 3];
        policy_o.rate1_skew_window = misc_q[SKEW1_LSB +: 4]; // R22
        policy_o.rate2_skew_window = misc_q[SKEW2_LSB +: 4]; // R22
        policy_o.rate3_skew_window = misc_q[SKEW3_LSB +: 4]; // R22
    end

    // forwarding start: whole-packet waits for the last beat, cut-through starts early
    logic whole_w;
    logic [LEN_W-1:0] mid_w;
    logic [LEN_W-1:0] thresh_w;
    logic [LEN_W-1:0] last_w;
    assign whole_w = fwd_q[STORE_BIT] || (pkt_nonposted_i && fwd_q[NPW_BIT]); // R1 R5
    assign mid_w = pkt_len_i >> 1;
    assign thresh_w = (mid_w > LEN_W'(fwd_q[EARLY_LSB +: 2])) ?
                      LEN_W'(mid_w - LEN_W'(fwd_q[EARLY_LSB +: 2])) : '0; // R2
    assign last_w = (pkt_len_i == '0) ? '0 : LEN_W'(pkt_len_i - 1'b1);
    assign fwd_start_o = whole_w ? (pkt_beat_i >= last_w) : (pkt_beat_i >= thresh_w);

    assign posted_hold_o = fwd_q[PNP_BIT] && np_pending_i; // R6

    logic [13:0] req_end;
    assign req_end = 14'(req_addr_i) + 14'(req_bytes_i);
    assign page_cross_o = fwd_q[PAGE_BIT] && (req_end > PAGE_BYTES); // R9

    ltc_rr_arbiter #(
        .PORTS(PORTS)
    ) u_arb (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .hold_i(fwd_q[HOLD_BIT]), // R3 R4
        .advance_i(arb_advance_i),
        .req_i(arb_req_i),
        .credit_ok_i(arb_credit_ok_i),
        .grant_o(arb_grant_o)
    );

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence dll_one_write_s;
        dll_wr_one;
    endsequence
    sequence nak_rx_seen_s;
        link_evt_i.nak_rx ##0 1'b1;
    endsequence

    bus_ack_a: assert property (cfg_req_i.valid |=> cfg_ack_o && // R23
        ($past(cfg_req_i.write) || $past(hit_w[3]) || cfg_rdata_o == $past(next_rdata)))
        else $error("register read answer wrong");
    store_whole_a: assert property (fwd_q[STORE_BIT] && pkt_beat_i < last_w |-> // R1
        !fwd_start_o) else $error("whole packet forwarded early");
    early_start_a: assert property (!whole_w && pkt_beat_i == thresh_w |-> // R2
        fwd_start_o) else $error("cut-through start missed");
    np_whole_a: assert property (pkt_nonposted_i && fwd_q[NPW_BIT] && pkt_beat_i < last_w |-> // R5
        !fwd_start_o) else $error("non-posted forwarded early");
    posted_hold_a: assert property (fwd_q[PNP_BIT] && np_pending_i |-> posted_hold_o) // R6
        else $error("posted packet allowed to pass");
    page_off_a: assert property (!fwd_q[PAGE_BIT] |-> !page_cross_o) // R9
        else $error("page check while disabled");
    ack_range_a: assert property (is_wr && hit_w[3] && hit_w[2:0] == IDX_LINK_ERR && // R10
        cfg_req_i.be[1] && rcv_wr == 3'h7 |=> $stable(link_err_q[RCV_ACK_LSB +: 3]))
        else $error("receive ack count took 7");
    nak_record_a: assert property (nak_rx_seen_s |=> rx_nak_flag && // R17
        rx_nak_seq == $past(link_evt_i.nak_rx_seq)) else $error("nak not recorded");
    flag_sticky_a: assert property (link_evt_i.sequence_fault_seen && !dll_rst && // R15
        !dll_wr_one |=> flags[2] [*2]) else $error("sequence fault flag lost");
    tally_clear_a: assert property (!tally_run |=> tally == 4'h0) // R12
        else $error("tally not cleared");
    dll_flip_a: assert property (dll_one_write_s |=> dll_rst != $past(dll_rst)) // R13
        else $error("link reset bit did not flip");
    nak_tx_a: assert property (link_evt_i.nak_tx |=> tx_nak_flag && // R17
        tx_nak_seq == $past(link_evt_i.nak_tx_seq)) else $error("transmit nak not recorded");
    // a quiet cycle under link-layer reset must leave every flag clear
    dll_clear_a: assert property (dll_rst && evt_flags == 10'h000 |=> flags == 10'h000) // R13
        else $error("flags kept under link reset");
    whole_start_a: assert property (whole_w && pkt_len_i != '0 && // R1 R5
        pkt_beat_i == last_w |-> fwd_start_o) else $error("whole packet start missed");
    posted_free_a: assert property (!fwd_q[PNP_BIT] |-> !posted_hold_o) // R6
        else $error("posted packet held without ordering rule");
    page_cross_a: assert property (fwd_q[PAGE_BIT] && req_end > PAGE_BYTES |-> // R9
        page_cross_o) else $error("page crossing missed");
    xmit_range_a: assert property (is_wr && hit_w[3] && hit_w[2:0] == IDX_LINK_ERR && // R11
        cfg_req_i.be[2] && xmit_wr == 3'h7 |=> $stable(link_err_q[XMIT_ACK_LSB +: 3]))
        else $error("transmit ack count took 7");
    tally_count_a: assert property (tally_run && b2b_pulse_i && tally != 4'hF |=> // R12
        tally == $past(tally) + 4'h1) else $error("tally missed a pulse");
endmodule

// [test/tb_top.sv]
// self-checking bench for the link and transaction register bank
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ltc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    ltc_cfg_req_t req = '0;
    ltc_link_evt_t evt = '0;
    logic b2b = 1'b0;
    logic np_pend = 1'b0;
    logic np_pkt = 1'b0;
    logic [9:0] beat = '0;
    logic [11:0] raddr = '0;
    logic [12:0] rbytes = '0;
    logic [3:0] areq = '0;
    logic [3:0] acred = '0;
    logic ack, fwd, phold, pcross;
    logic [31:0] rdata, v;
    logic [3:0] grant;
    ltc_policy_t pol;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    ltc_csr_bank i_ltc_csr_bank (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_req_i(req),
        .cfg_ack_o(ack), .cfg_rdata_o(rdata), .link_evt_i(evt), .b2b_pulse_i(b2b),
        .strap_cross_domain_i(1'b0), .strap_up_port_i(3'h0), .strap_mem_share_off_i(1'b0),
        .policy_o(pol), .pkt_len_i(10'h014), .pkt_beat_i(beat), .pkt_nonposted_i(np_pkt),
        .fwd_start_o(fwd), .np_pending_i(np_pend), .posted_hold_o(phold),
        .req_addr_i(raddr), .req_bytes_i(rbytes), .page_cross_o(pcross),
        .arb_advance_i(1'b0), .arb_req_i(areq), .arb_credit_ok_i(acred), .arb_grant_o(grant));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_sys_i);
        req = '{1'b1, w, a, d, 4'hF};
        @(negedge clk_sys_i);
        req.valid = 1'b0;
        chk(32'(ack), 32'h1);
        v = rdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        chk(v, e);
    endtask
    task automatic stop_test();
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // generous ceiling, the sequence needs about 70 cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        rd(OFF_LINK_ERR, LINK_ERR_RSVD_NARROW | 32'h3000);
        rd(OFF_MISC_CTRL, 32'h0CCC_2C81);
        rd(OFF_TL_CAP, 32'h1);
        rd(OFF_FWD_ORDER, 32'h8008);
        acc(1'b1, OFF_LINK_TX_DBG, '1);
        rd(OFF_LINK_TX_DBG, 32'h70);
        rd(12'h500, 32'h0);
        acc(1'b1, OFF_LINK_ERR, 32'hFFFF_7FFF);
        rd(OFF_LINK_ERR, LINK_ERR_RSVD_NARROW | 32'h3000);
        acc(1'b1, OFF_LINK_ERR, 32'h0006_5000);
        rd(OFF_LINK_ERR, LINK_ERR_RSVD_NARROW | 32'h0006_5000);
        evt = {10'h3FF, 2'b11, 12'h123, 12'hABC};
        @(negedge clk_sys_i);
        evt = '0;
        rd(OFF_NAK_REC, 32'h8ABC_8123);
        rd(OFF_LINK_ERR, LINK_ERR_RSVD_NARROW | 32'h0006_53FF);
        acc(1'b1, OFF_MISC_CTRL, 32'h0CCC_2C83);
        chk(32'(pol.dll_reset), 32'h1);
        rd(OFF_LINK_ERR, LINK_ERR_RSVD_NARROW | 32'h0006_5000);
        acc(1'b1, OFF_MISC_CTRL, 32'h0CCC_2C83);
        chk(32'(pol.dll_reset), 32'h0);
        acc(1'b1, OFF_TALLY_CTRL, 32'h7FD);
        b2b = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        b2b = 1'b0;
        rd(OFF_TALLY_CTRL, 32'h3002_87FD);
        acc(1'b1, OFF_TALLY_CTRL, 32'h7F9);
        rd(OFF_TALLY_CTRL, 32'h0002_87F9);
        // threshold walks down from mid-packet as the code rises
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, OFF_FWD_ORDER, 32'(c) << 1);
            beat = 10'(10 - c);
            #1 chk(32'(fwd), 32'h1);
            beat = 10'(9 - c);
            #1 chk(32'(fwd), 32'h0);
        end
        acc(1'b1, OFF_FWD_ORDER, 32'h1);
        beat = 10'd18;
        #1 chk(32'(fwd), 32'h0);
        acc(1'b1, OFF_FWD_ORDER, 32'h80);
        np_pkt = 1'b1;
        #1 chk(32'(fwd), 32'h0);
        beat = 10'h013;
        #1 chk(32'(fwd), 32'h1);
        np_pkt = 1'b0;
        beat = 10'h00A;
        #1 chk(32'(fwd), 32'h1);
        acc(1'b1, OFF_FWD_ORDER, 32'h2800);
        np_pend = 1'b1;
        raddr = 12'hF00;
        rbytes = 13'h101;
        #1 chk(32'(phold), 32'h1);
        chk(32'(pcross), 32'h1);
        rbytes = 13'h100;
        #1 chk(32'(pcross), 32'h0);
        areq = 4'b0110;
        acred = 4'b0010;
        repeat (2) @(negedge clk_sys_i);
        chk(32'(grant), 32'h2);
        acred = 4'b0100;
        repeat (2) @(negedge clk_sys_i);
        chk(32'(grant), 32'h4);
        acc(1'b1, OFF_FWD_ORDER, 32'h10);
        acred = 4'b0000;
        repeat (3) @(negedge clk_sys_i);
        chk(32'(grant), 32'h4);
        stop_test();
    end
endmodule
